// ### rtl/imc_defines.vh
// Shared constants for the inter-domain management message codec.
`ifndef IMC_DEFINES_VH
`define IMC_DEFINES_VH

// Register byte offsets on the Wishbone slave.
`define IMC_REG_CTRL 8'h00
`define IMC_REG_STATUS 8'h04
`define IMC_REG_LOCAL_ID 8'h08
`define IMC_REG_CLUSTER_LO 8'h0c
`define IMC_REG_CLUSTER_HI 8'h10
`define IMC_REG_MASTER_LO 8'h14
`define IMC_REG_MASTER_HI 8'h18
`define IMC_REG_DOMAIN_ID 8'h1c
`define IMC_REG_REPORT_CFG 8'h20
`define IMC_REG_TX_DATA 8'h24
`define IMC_REG_RX_TARGET 8'h28
`define IMC_REG_RX_SHIFT 8'h2c
`define IMC_REG_RX_PEER 8'h30
`define IMC_REG_RX_REPORT 8'h34

// Control bit positions and reset value.
`define IMC_CTRL_AUTO_CONFIRM 0
`define IMC_CTRL_SEND_CONFIRM 1
`define IMC_CTRL_SEND_REPORT 2
`define IMC_CTRL_OUTCOME 3
`define IMC_CTRL_RESET 4'h1

// Message kinds on the octet streams.
`define IMC_KIND_REQUEST 2'h0
`define IMC_KIND_CONFIRM 2'h1
`define IMC_KIND_REPORT 2'h2

// Fixed octet positions; all but the target count, which only requests carry, are shared by all three payloads.
`define IMC_OCT_CLUSTER 5'h02
`define IMC_OCT_MASTER 5'h08
`define IMC_OCT_DOMAIN 5'h0e
`define IMC_OCT_KIND_FIELD 5'h11
`define IMC_OCT_TARGET_COUNT 5'h12

`endif

// ### rtl/imc_codec.v
// Management message codec: octet FIFO, framer, parser and Wishbone registers.
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "imc_defines.vh"

// Small synchronous FIFO with valid and ready on both sides.
module imc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire mclk,
    input wire srst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];

    // Pointers wrap at DEPTH so non-power-of-two depths still work.
    always @(posedge mclk) begin
        if (srst) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // Storage needs no reset; empty entries are never presented.
    always @(posedge mclk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
endmodule

// Codec top: builds confirmations and victim reports, parses incoming messages.
module imc_codec #(
    parameter FIFO_DEPTH = 4
) (
    input wire mclk,
    input wire srst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    output reg tx_valid,
    input wire tx_ready,
    output reg [7:0] tx_data,
    output reg tx_last,
    output reg [1:0] tx_kind,
    input wire rx_valid,
    output wire rx_ready,
    input wire [7:0] rx_data,
    input wire rx_last,
    input wire [1:0] rx_kind
);
    localparam TX_IDLE = 2'd0;
    localparam TX_HDR = 2'd1;
    localparam TX_BODY = 2'd2;
    localparam RX_HDR = 3'd0;
    localparam RX_LIST = 3'd1;
    localparam RX_SHIFT = 3'd2;
    localparam RX_LEN = 3'd3;
    localparam RX_BODY = 3'd4;
    localparam RX_DRAIN = 3'd5;

    // Software-visible configuration.
    reg [3:0] ctrl_q;
    reg [7:0] node_q;
    reg [7:0] designator_q;
    reg [47:0] cluster_q;
    reg [47:0] master_q;
    reg [23:0] domain_q;
    reg [7:0] rep_count_q;
    reg [15:0] rep_body_q;
    // Status and parse results.
    reg [4:0] sticky_q;
    reg confirm_pend_q;
    reg report_pend_q;
    reg [7:0] target_count_q;
    reg [23:0] last_target_q;
    reg [31:0] shift_q;
    reg [23:0] peer_domain_q;
    reg [7:0] peer_outcome_q;
    reg [7:0] peer_tables_q;
    reg [7:0] tables_done_q;
    reg [7:0] first_victims_q;
    reg ack_q;

    // Octet n of a little-endian multi-octet field.
    function [7:0] field_octet;
        input [47:0] val;
        input [2:0] n;
        begin
            field_octet = val[8*n +: 8];
        end
    endfunction

    // Common header octets 0..16 followed by the kind-specific octet 17.
    function [7:0] hdr_octet;
        input [4:0] idx;
        input [1:0] kind;
        input [7:0] node;
        input [7:0] desig;
        input [47:0] clus;
        input [47:0] mast;
        input [23:0] dom;
        input outcome;
        input [7:0] count;
        begin
            if (idx == 5'h00) begin
                hdr_octet = node;
            end else if (idx == 5'h01) begin
                hdr_octet = desig;
            end else if (idx < `IMC_OCT_MASTER) begin
                hdr_octet = field_octet(clus, idx[2:0] - 3'd2);
            end else if (idx < `IMC_OCT_DOMAIN) begin
                hdr_octet = field_octet(mast, idx[2:0]);
            end else if (idx < `IMC_OCT_KIND_FIELD) begin
                hdr_octet = field_octet({24'h000000, dom}, idx[2:0] - 3'd6);
            end else if (kind == `IMC_KIND_CONFIRM) begin
                hdr_octet = {7'h00, outcome};
            end else begin
                hdr_octet = count;
            end
        end
    endfunction

    // Wishbone decode; data writes stall while the FIFO is full.
    wire wb_req = wb_cyc_i && wb_stb_i && !ack_q;
    wire sel_data = (wb_adr_i == `IMC_REG_TX_DATA);
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire fifo_pop;
    wire fifo_push = wb_req && wb_we_i && sel_data && wb_sel_i[0];
    wire wb_take = wb_req && (!(wb_we_i && sel_data && wb_sel_i[0]) || fifo_in_ready);
    wire wr = wb_take && wb_we_i;
    assign wb_ack_o = ack_q;
    assign rx_ready = 1'b1;

    // Body octets of the victim report pass through this buffer.
    imc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(2)) u_fifo (
        .mclk(mclk),
        .srst(srst),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(wb_dat_i[7:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // Transmit framer state.
    reg [1:0] tx_st_q;
    reg [4:0] tx_idx_q;
    reg [15:0] tx_left_q;
    wire tx_adv = !tx_valid || tx_ready;
    assign fifo_pop = (tx_st_q == TX_BODY) && tx_adv && fifo_out_valid;

    // Receive parser state.
    reg [2:0] rx_st_q;
    reg [4:0] rx_idx_q;
    reg [1:0] rx_kind_q;
    reg [15:0] rx_left_q;
    reg [1:0] rx_pos_q;
    reg [15:0] rx_len_q;
    reg rx_first_q;
    wire rx_take = rx_valid;
    wire [1:0] kind_now = (rx_idx_q == 5'h00 && rx_st_q == RX_HDR) ? rx_kind : rx_kind_q;
    reg rx_done;
    reg rx_err;

    // Register writes, sticky flags and command pending bits.
    always @(posedge mclk) begin
        if (srst) begin
            ctrl_q <= `IMC_CTRL_RESET;
            node_q <= 8'h00;
            designator_q <= 8'h00;
            cluster_q <= 48'h000000000000;
            master_q <= 48'h000000000000;
            domain_q <= 24'h000000;
            rep_count_q <= 8'h00;
            rep_body_q <= 16'h0000;
            sticky_q <= 5'h00;
            confirm_pend_q <= 1'b0;
            report_pend_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_take;
            if (wr && wb_adr_i == `IMC_REG_CTRL && wb_sel_i[0]) begin
                ctrl_q[`IMC_CTRL_AUTO_CONFIRM] <= wb_dat_i[`IMC_CTRL_AUTO_CONFIRM];
                ctrl_q[`IMC_CTRL_OUTCOME] <= wb_dat_i[`IMC_CTRL_OUTCOME];
            end
            if (wr && wb_adr_i == `IMC_REG_LOCAL_ID) begin
                if (wb_sel_i[0]) node_q <= wb_dat_i[7:0];
                if (wb_sel_i[1]) designator_q <= wb_dat_i[15:8];
            end
            if (wr && wb_adr_i == `IMC_REG_CLUSTER_LO) cluster_q[31:0] <= wb_dat_i;
            if (wr && wb_adr_i == `IMC_REG_CLUSTER_HI) cluster_q[47:32] <= wb_dat_i[15:0];
            if (wr && wb_adr_i == `IMC_REG_MASTER_LO) master_q[31:0] <= wb_dat_i;
            if (wr && wb_adr_i == `IMC_REG_MASTER_HI) master_q[47:32] <= wb_dat_i[15:0];
            if (wr && wb_adr_i == `IMC_REG_DOMAIN_ID) domain_q <= wb_dat_i[23:0];
            if (wr && wb_adr_i == `IMC_REG_REPORT_CFG) begin
                rep_count_q <= wb_dat_i[7:0];
                rep_body_q <= wb_dat_i[31:16];
            end
            // Flags clear by writing one; a same-cycle set still wins.
            sticky_q <= (wr && wb_adr_i == `IMC_REG_STATUS) ? sticky_q & ~wb_dat_i[5:1] : sticky_q;
            if (rx_done && rx_kind_q == `IMC_KIND_REQUEST) sticky_q[0] <= 1'b1;
            if (rx_done && rx_kind_q == `IMC_KIND_CONFIRM) sticky_q[1] <= 1'b1;
            if (rx_done && rx_kind_q == `IMC_KIND_REPORT) sticky_q[2] <= 1'b1;
            if (rx_err) sticky_q[3] <= 1'b1;
            if (rx_done && rx_kind_q == `IMC_KIND_CONFIRM && peer_outcome_q > 8'h01) begin
                sticky_q[4] <= 1'b1;
            end
            // A finished request queues its confirmation automatically.
            if (rx_done && rx_kind_q == `IMC_KIND_REQUEST && ctrl_q[`IMC_CTRL_AUTO_CONFIRM]) begin
                confirm_pend_q <= 1'b1;
            end else if (wr && wb_adr_i == `IMC_REG_CTRL && wb_dat_i[`IMC_CTRL_SEND_CONFIRM]) begin
                confirm_pend_q <= 1'b1;
            end else if (tx_st_q == TX_IDLE && tx_adv) begin
                // Clear only when the framer really leaves idle, or a stalled last octet loses it.
                confirm_pend_q <= 1'b0;
            end
            if (wr && wb_adr_i == `IMC_REG_CTRL && wb_dat_i[`IMC_CTRL_SEND_REPORT]) begin
                report_pend_q <= 1'b1;
            end else if (tx_st_q == TX_IDLE && tx_adv && !confirm_pend_q) begin
                report_pend_q <= 1'b0;
            end
        end
    end

    // Registered read data, taken on the same edge that raises ack.
    always @(posedge mclk) begin
        if (srst) begin
            wb_dat_o <= 32'h00000000;
        end else if (wb_take && !wb_we_i) begin
            case (wb_adr_i)
                `IMC_REG_CTRL: wb_dat_o <= {28'h0000000, ctrl_q & 4'h9};
                `IMC_REG_STATUS: wb_dat_o <= {26'h0, sticky_q, tx_st_q != TX_IDLE};
                `IMC_REG_LOCAL_ID: wb_dat_o <= {16'h0000, designator_q, node_q};
                `IMC_REG_CLUSTER_LO: wb_dat_o <= cluster_q[31:0];
                `IMC_REG_CLUSTER_HI: wb_dat_o <= {16'h0000, cluster_q[47:32]};
                `IMC_REG_MASTER_LO: wb_dat_o <= master_q[31:0];
                `IMC_REG_MASTER_HI: wb_dat_o <= {16'h0000, master_q[47:32]};
                `IMC_REG_DOMAIN_ID: wb_dat_o <= {8'h00, domain_q};
                `IMC_REG_REPORT_CFG: wb_dat_o <= {rep_body_q, 8'h00, rep_count_q};
                `IMC_REG_RX_TARGET: wb_dat_o <= {target_count_q, last_target_q};
                `IMC_REG_RX_SHIFT: wb_dat_o <= shift_q;
                `IMC_REG_RX_PEER: wb_dat_o <= {peer_outcome_q, peer_domain_q};
                `IMC_REG_RX_REPORT: wb_dat_o <= {8'h00, first_victims_q, tables_done_q, peer_tables_q};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // Framer: 18 header octets, then the report body from the FIFO.
    // Confirmations take priority so a peer's request is never starved.
    always @(posedge mclk) begin
        if (srst) begin
            tx_st_q <= TX_IDLE;
            tx_idx_q <= 5'h00;
            tx_left_q <= 16'h0000;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
            tx_kind <= 2'h0;
        end else if (tx_adv) begin
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
            case (tx_st_q)
                TX_IDLE: begin
                    tx_idx_q <= 5'h00;
                    if (confirm_pend_q) begin
                        tx_kind <= `IMC_KIND_CONFIRM;
                        tx_left_q <= 16'h0000;
                        tx_st_q <= TX_HDR;
                    end else if (report_pend_q) begin
                        tx_kind <= `IMC_KIND_REPORT;
                        tx_left_q <= rep_body_q;
                        tx_st_q <= TX_HDR;
                    end
                end
                TX_HDR: begin
                    tx_valid <= 1'b1;
                    tx_data <= hdr_octet(tx_idx_q, tx_kind, node_q, designator_q, cluster_q,
                        master_q, domain_q, ctrl_q[`IMC_CTRL_OUTCOME], rep_count_q);
                    tx_idx_q <= tx_idx_q + 5'h01;
                    if (tx_idx_q == `IMC_OCT_KIND_FIELD) begin
                        tx_last <= (tx_left_q == 16'h0000);
                        tx_st_q <= (tx_left_q == 16'h0000) ? TX_IDLE : TX_BODY;
                    end
                end
                TX_BODY: begin
                    // Software supplies lengths and tables as raw octets.
                    if (fifo_out_valid) begin
                        tx_valid <= 1'b1;
                        tx_data <= fifo_out_data;
                        tx_left_q <= tx_left_q - 16'h0001;
                        tx_last <= (tx_left_q == 16'h0001);
                        if (tx_left_q == 16'h0001) tx_st_q <= TX_IDLE;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // Parser: every accepted octet outside the drain state moves the walk by one octet position.
    always @(posedge mclk) begin
        if (srst) begin
            rx_st_q <= RX_HDR;
            rx_idx_q <= 5'h00;
            rx_kind_q <= 2'h0;
            rx_left_q <= 16'h0000;
            rx_pos_q <= 2'h0;
            rx_len_q <= 16'h0000;
            rx_first_q <= 1'b0;
            rx_done <= 1'b0;
            rx_err <= 1'b0;
            target_count_q <= 8'h00;
            last_target_q <= 24'h000000;
            shift_q <= 32'h00000000;
            peer_domain_q <= 24'h000000;
            peer_outcome_q <= 8'h00;
            peer_tables_q <= 8'h00;
            tables_done_q <= 8'h00;
            first_victims_q <= 8'h00;
        end else begin
            rx_done <= 1'b0;
            rx_err <= 1'b0;
            if (rx_take) begin
                rx_kind_q <= kind_now;
                case (rx_st_q)
                    RX_HDR: begin
                        rx_idx_q <= rx_idx_q + 5'h01;
                        if (rx_idx_q >= `IMC_OCT_DOMAIN && rx_idx_q < `IMC_OCT_KIND_FIELD) begin
                            // Octets 14 to 16 map to bytes 0 to 2 of the domain identifier.
                            peer_domain_q[8*(rx_idx_q - `IMC_OCT_DOMAIN) +: 8] <= rx_data;
                        end
                        if (rx_idx_q == `IMC_OCT_KIND_FIELD) begin
                            if (kind_now == `IMC_KIND_CONFIRM) begin
                                peer_outcome_q <= rx_data;
                                rx_done <= 1'b1;
                                rx_st_q <= RX_DRAIN;
                            end else if (kind_now == `IMC_KIND_REPORT) begin
                                peer_tables_q <= rx_data;
                                tables_done_q <= 8'h00;
                                rx_left_q <= {8'h00, rx_data};
                                rx_pos_q <= 2'h0;
                                rx_first_q <= 1'b1;
                                rx_done <= (rx_data == 8'h00);
                                rx_st_q <= (rx_data == 8'h00) ? RX_DRAIN : RX_LEN;
                            end
                            // Request offset octet carries nothing needed here.
                        end
                        if (rx_idx_q == `IMC_OCT_TARGET_COUNT) begin
                            target_count_q <= rx_data;
                            rx_left_q <= {8'h00, rx_data};
                            rx_pos_q <= 2'h0;
                            rx_st_q <= (rx_data == 8'h00) ? RX_SHIFT : RX_LIST;
                        end
                    end
                    RX_LIST: begin
                        // Each entry overwrites, so the last one remains.
                        last_target_q[8*rx_pos_q +: 8] <= rx_data;
                        rx_pos_q <= (rx_pos_q == 2'h2) ? 2'h0 : rx_pos_q + 2'h1;
                        if (rx_pos_q == 2'h2) begin
                            rx_left_q <= rx_left_q - 16'h0001;
                            if (rx_left_q == 16'h0001) rx_st_q <= RX_SHIFT;
                        end
                    end
                    RX_SHIFT: begin
                        // Bit 0 is direction, bits 31:1 the shift amount.
                        shift_q[8*rx_pos_q +: 8] <= rx_data;
                        rx_pos_q <= rx_pos_q + 2'h1;
                        if (rx_pos_q == 2'h3) begin
                            rx_done <= 1'b1;
                            rx_st_q <= RX_DRAIN;
                        end
                    end
                    RX_LEN: begin
                        rx_len_q[8*rx_pos_q[0] +: 8] <= rx_data;
                        rx_pos_q <= {1'b0, ~rx_pos_q[0]};
                        if (rx_pos_q[0]) begin
                            if ({rx_data, rx_len_q[7:0]} == 16'h0000) begin
                                tables_done_q <= tables_done_q + 8'h01;
                                rx_left_q <= rx_left_q - 16'h0001;
                                rx_first_q <= 1'b0;
                                rx_done <= (rx_left_q == 16'h0001);
                                if (rx_left_q == 16'h0001) rx_st_q <= RX_DRAIN;
                            end else begin
                                rx_len_q <= {rx_data, rx_len_q[7:0]};
                                rx_st_q <= RX_BODY;
                            end
                        end
                    end
                    RX_BODY: begin
                        // Only octet 0 of the first table is decoded; the rest is stepped over.
                        if (rx_first_q) first_victims_q <= rx_data;
                        rx_first_q <= 1'b0;
                        rx_len_q <= rx_len_q - 16'h0001;
                        if (rx_len_q == 16'h0001) begin
                            tables_done_q <= tables_done_q + 8'h01;
                            rx_left_q <= rx_left_q - 16'h0001;
                            rx_done <= (rx_left_q == 16'h0001);
                            rx_st_q <= (rx_left_q == 16'h0001) ? RX_DRAIN : RX_LEN;
                        end
                    end
                    default: begin
                        rx_st_q <= RX_DRAIN;
                    end
                endcase
                // Frame end resets the walk; ending before completion is an error.
                if (rx_last) begin
                    rx_st_q <= RX_HDR;
                    rx_idx_q <= 5'h00;
                    rx_pos_q <= 2'h0;
                    if (rx_st_q != RX_DRAIN && !(rx_st_q == RX_SHIFT && rx_pos_q == 2'h3)
                        && !(rx_st_q == RX_HDR && rx_idx_q == `IMC_OCT_KIND_FIELD
                        && kind_now == `IMC_KIND_CONFIRM)
                        && !(rx_st_q == RX_HDR && rx_idx_q == `IMC_OCT_KIND_FIELD
                        && kind_now == `IMC_KIND_REPORT && rx_data == 8'h00)
                        && !(rx_st_q == RX_BODY && rx_len_q == 16'h0001 && rx_left_q == 16'h0001)
                        && !(rx_st_q == RX_LEN && rx_pos_q[0] && rx_left_q == 16'h0001
                        && {rx_data, rx_len_q[7:0]} == 16'h0000)) begin
                        rx_err <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

// ### tb/imc_codec_chk.sv
// Checker that watches the codec's bus and outgoing octet stream ports.
`timescale 1ns/1ps
module imc_codec_chk (
    input wire mclk,
    input wire srst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire wb_ack_o,
    input wire tx_valid,
    input wire tx_ready,
    input wire [7:0] tx_data,
    input wire tx_last,
    input wire [1:0] tx_kind,
    input wire rx_ready
);
    reg [7:0] oct_q;
    // Octet index within the outgoing frame; it clears after the final octet.
    always @(posedge mclk) begin
        if (srst || (tx_valid && tx_ready && tx_last)) oct_q <= 8'h00;
        else if (tx_valid && tx_ready) oct_q <= oct_q + 8'h01;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_read_answer: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o |=> wb_ack_o)
        else $error("read not answered");
    a_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable({tx_data, tx_last}))
        else $error("octet dropped while stalled");
    a_rx_open: assert property (rx_ready)
        else $error("receiver refused");
    a_kind_legal: assert property (tx_valid |-> tx_kind == 2'h1 || tx_kind == 2'h2)
        else $error("bad kind");
    a_confirm_end: assert property (tx_valid && tx_kind == 2'h1 |-> tx_last == (oct_q == 8'h11))
        else $error("confirm length");
    a_outcome_code: assert property (tx_valid && tx_kind == 2'h1 && oct_q == 8'h11 |-> tx_data <= 8'h01)
        else $error("reserved outcome sent");
    a_report_hdr: assert property (tx_valid && tx_kind == 2'h2 && oct_q < 8'h11 |-> !tx_last)
        else $error("report too short");
endmodule
bind imc_codec imc_codec_chk chk_u (.mclk(mclk), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .tx_kind(tx_kind),
    .rx_ready(rx_ready));

// ### tb/imc_peer.sv
// Peer node model: sends frames into the codec and collects what it sends back.
`timescale 1ns/1ps
module imc_peer (
    input wire mclk,
    output reg rx_valid = 1'b0,
    output reg [7:0] rx_data = 8'h00,
    output reg rx_last = 1'b0,
    output reg [1:0] rx_kind = 2'h0,
    input wire tx_valid,
    input wire [7:0] tx_data,
    input wire tx_last,
    output reg tx_ready = 1'b0
);
    reg [8:0] got[$];
    reg slow = 1'b0;
    // Slow mode drops ready every other cycle so the codec must hold its octet.
    always @(posedge mclk) begin
        if (tx_valid && tx_ready) got.push_back({tx_last, tx_data});
        tx_ready <= !slow || !tx_ready;
    end
    // Idle data shows the inverse of the last octet, so stale values never match.
    task send(input [1:0] k, input reg [7:0] f[$]);
        integer i;
        for (i = 0; i < f.size(); i = i + 1) begin
            @(posedge mclk);
            rx_valid <= 1'b1;
            rx_kind <= k;
            rx_data <= f[i];
            rx_last <= i == f.size() - 1;
        end
        @(posedge mclk);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~rx_data;
    endtask
endmodule

// ### tb/tb_inter_domain_mgmt_msg_codec.sv
// Self-checking bench for the inter-domain management message codec.
`timescale 1ns/1ps
module tb_inter_domain_mgmt_msg_codec;
    reg mclk = 1'b0;
    reg srst = 1'b1;
    reg cyc = 1'b0;
    reg we = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [31:0] dat = 32'h0;
    reg [31:0] r;
    reg [7:0] hq[$];
    integer miscompares = 0;
    integer check_count = 0;
    integer n;
    wire [31:0] rdat;
    wire ack, tx_valid, tx_ready, tx_last, rx_valid, rx_ready, rx_last;
    wire [7:0] tx_data, rx_data;
    wire [1:0] tx_kind, rx_kind;
    always #5 mclk = ~mclk;
    imc_codec dut_u (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last),
        .tx_kind(tx_kind), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .rx_last(rx_last), .rx_kind(rx_kind));
    imc_peer p (.mclk(mclk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_kind(rx_kind), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready));
    task chk(input [31:0] seen, input [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task tmo(input ok);
        if (!ok) begin
            chk(0, 1);
            print_verdict;
        end
    endtask
    // One classic cycle; read data is taken at the edge that shows ack.
    task bus(input w, input [7:0] a, input [31:0] d);
        integer i;
        @(posedge mclk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        i = 0;
        do begin
            @(posedge mclk);
            i = i + 1;
        end while (ack !== 1'b1 && i < 300);
        r = rdat;
        cyc <= 1'b0;
        tmo(ack === 1'b1);
    endtask
    // Common header octets 0 to 16 carry 10h plus their index, so any misplaced field shows.
    task chk_frame(input reg [7:0] t[$]);
        integer k;
        for (k = 0; k < 900 && p.got.size() < 17 + t.size(); k = k + 1) @(posedge mclk);
        tmo(p.got.size() == 17 + t.size());
        for (k = 0; k < 17 + t.size(); k = k + 1)
            chk(p.got[k], {k == 16 + t.size(), k < 17 ? 8'h10 + k[7:0] : t[k - 17]});
        p.got = {};
    endtask
    task t_regs;
        bus(0, 8'h00, 0);
        chk(r, 32'h1);
        bus(0, 8'h3c, 0);
        chk(r, 32'h0);
        bus(1, 8'h08, 32'h0000_1110);
        bus(1, 8'h0c, 32'h1514_1312);
        bus(1, 8'h10, 32'h0000_1716);
        bus(1, 8'h14, 32'h1b1a_1918);
        bus(1, 8'h18, 32'h0000_1d1c);
        bus(1, 8'h1c, 32'h0020_1f1e);
        $display("regs done");
    endtask
    task t_request;
        p.slow = 1'b1;
        p.send(0, {hq, 8'he0, 8'h02, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h21, 8'h43,
            8'h65, 8'h87});
        chk_frame({8'h00});
        bus(0, 8'h28, 0);
        chk(r, 32'h0206_0504);
        bus(0, 8'h2c, 0);
        chk(r, 32'h8765_4321);
        bus(1, 8'h00, 32'hb);
        chk_frame({8'h01});
        $display("request done");
    endtask
    // The fifth body octet is refused until the frame starts draining the FIFO.
    task t_report_tx;
        bus(1, 8'h20, 32'h0005_0001);
        bus(1, 8'h24, 32'h03);
        bus(1, 8'h24, 32'h00);
        bus(1, 8'h24, 32'h02);
        bus(1, 8'h24, 32'h07);
        bus(1, 8'h00, 32'h5);
        bus(1, 8'h24, 32'h09);
        chk_frame({8'h01, 8'h03, 8'h00, 8'h02, 8'h07, 8'h09});
        $display("report tx done");
    endtask
    task t_report_rx;
        p.send(2, {hq, 8'h02, 8'h02, 8'h00, 8'h03, 8'haa, 8'h00, 8'h00});
        bus(0, 8'h34, 0);
        chk(r & 32'hff_ffff, 32'h03_0202);
        bus(0, 8'h04, 0);
        chk(r & 32'h8, 32'h8);
        // A confirmation with a reserved outcome code must still be parsed and flagged.
        p.send(1, {hq, 8'h05});
        bus(0, 8'h30, 0);
        chk(r, 32'h0550_4f4e);
        bus(0, 8'h04, 0);
        chk(r, 32'h0000_002e);
        $display("report rx done");
    endtask
    initial begin
        for (n = 0; n < 17; n = n + 1) hq.push_back(8'h40 + n[7:0]);
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        t_regs;
        t_request;
        t_report_tx;
        t_report_rx;
        print_verdict;
    end
endmodule
